//--- src/vis_pkg.sv
// Shared constants, encodings and state codes for the vector issue scoreboard.
// Assumes one core clock; every user of these names writes vis_pkg::name.
package vis_pkg;
  localparam int NREG = 16;
  localparam int REG_W = 4;
  localparam int VL_MAX = 64;
  localparam int IDX_W = 6;
  localparam int VL_W = 7;
  localparam int ADDR_W = 32;
  localparam int MASK_W = 64;
  localparam logic [MASK_W-1:0] MASK_ALL = {MASK_W{1'b1}};

  typedef enum logic [2:0] {
    OP_ARITH = 3'h0,
    OP_DIV = 3'h1,
    OP_LOAD = 3'h2,
    OP_STORE = 3'h3,
    OP_GATHER = 3'h4,
    OP_SCATTER = 3'h5
  } vis_op_e;

  typedef enum logic [2:0] {
    LK_LOAD = 3'h0,
    LK_STORE = 3'h1,
    LK_OFFSET = 3'h2,
    LK_GATHER = 3'h3,
    LK_SCATTER = 3'h4
  } vis_lsu_e;

  typedef enum logic [6:0] {
    M_IDLE = 7'h01,
    M_MASKW = 7'h02,
    M_MASKF = 7'h04,
    M_CHECK = 7'h08,
    M_CHAIN = 7'h10,
    M_OFFS = 7'h20,
    M_RUN = 7'h40
  } vis_mem_e;
endpackage

//--- src/vis_reg_mask.sv
// One-hot vector register usage mask from a register number.
// Assumes the number is below NREG.
`timescale 1ns/1ps
module vis_reg_mask #(
  parameter int NREG = vis_pkg::NREG,
  parameter int REG_W = vis_pkg::REG_W
) (
  input wire logic en,
  input wire logic [REG_W-1:0] reg_num,
  output logic [NREG-1:0] hot
);
  wire [NREG-1:0] one = {{(NREG-1){1'b0}}, 1'b1};

  assign hot = en ? (one << reg_num) : {NREG{1'b0}};
endmodule

//--- src/vis_offset_store.sv
// Offset vector store and element address generator for gather and scatter.
// Assumes the load/store unit writes offsets before it requests elements.
`timescale 1ns/1ps
module vis_offset_store #(
  parameter int DEPTH = vis_pkg::VL_MAX,
  parameter int IDX_W = vis_pkg::IDX_W,
  parameter int ADDR_W = vis_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [ADDR_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [IDX_W-1:0] rd_idx,
  input wire logic [IDX_W:0] vlen,
  input wire logic [ADDR_W-1:0] base,
  output logic out_valid,
  output logic [ADDR_W-1:0] out_addr,
  output logic [IDX_W-1:0] out_idx
);
  logic [ADDR_W-1:0] offs [DEPTH];
  logic out_valid_q;
  logic [ADDR_W-1:0] out_addr_q;
  logic [IDX_W-1:0] out_idx_q;
  wire in_range = {1'b0, rd_idx} < vlen;
  wire take = rd_en && in_range;
  wire [ADDR_W-1:0] sum = base + offs[rd_idx];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      offs[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      out_valid_q <= 1'b0;
      out_addr_q <= '0;
      out_idx_q <= '0;
    end else begin
      out_valid_q <= take;
      if (take) begin
        out_addr_q <= sum;
        out_idx_q <= rd_idx;
      end
    end
  end

  assign out_valid = out_valid_q;
  assign out_addr = out_addr_q;
  assign out_idx = out_idx_q;
endmodule

//--- src/vis_top.sv
// Vector issue and scoreboard control: arithmetic slots, memory sequencing.
// Assumes the scalar issue unit holds an instruction until instr_ready.
`timescale 1ns/1ps
module vis_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [2:0] instr_op,
  input wire logic [vis_pkg::REG_W-1:0] instr_dst,
  input wire logic [vis_pkg::REG_W-1:0] instr_src_a,
  input wire logic [vis_pkg::REG_W-1:0] instr_src_b,
  input wire logic instr_masked,
  input wire logic instr_wr_mask,
  input wire logic [vis_pkg::ADDR_W-1:0] instr_base,
  input wire logic [vis_pkg::VL_W-1:0] vector_length_value,
  output logic arith_issue_valid,
  output logic arith_issue_deferred,
  output logic arith_issue_div,
  output logic [vis_pkg::REG_W-1:0] arith_issue_dst,
  output logic [vis_pkg::REG_W-1:0] arith_issue_src_a,
  output logic [vis_pkg::REG_W-1:0] arith_issue_src_b,
  input wire logic arith_done,
  input wire logic arith_chain_ok,
  output logic mask_req,
  input wire logic mask_valid,
  input wire logic [vis_pkg::MASK_W-1:0] mask_data,
  output logic lsu_cmd_valid,
  output logic [2:0] lsu_cmd_kind,
  output logic [vis_pkg::REG_W-1:0] lsu_cmd_vreg,
  output logic [vis_pkg::REG_W-1:0] lsu_cmd_offreg,
  output logic [vis_pkg::ADDR_W-1:0] lsu_cmd_base,
  output logic [vis_pkg::MASK_W-1:0] lsu_mask,
  input wire logic lsu_offsets_done,
  input wire logic lsu_done,
  input wire logic translation_safe_signal,
  output logic scalar_resume,
  input wire logic off_wr_valid,
  input wire logic [vis_pkg::IDX_W-1:0] off_wr_idx,
  input wire logic [vis_pkg::ADDR_W-1:0] off_wr_data,
  input wire logic elem_req,
  input wire logic [vis_pkg::IDX_W-1:0] elem_idx,
  output logic elem_valid,
  output logic [vis_pkg::ADDR_W-1:0] elem_addr,
  output logic [vis_pkg::IDX_W-1:0] elem_dst_idx,
  output logic [vis_pkg::NREG-1:0] sb_write_busy,
  output logic [vis_pkg::NREG-1:0] sb_read_busy
);
  localparam int RW = vis_pkg::REG_W;
  localparam int NR = vis_pkg::NREG;

  // Executing and deferred arithmetic slots
  logic cur_v_q, cur_div_q, cur_wm_q;
  logic [RW-1:0] cur_dst_q, cur_sa_q, cur_sb_q;
  logic def_v_q, def_div_q, def_wm_q;
  logic [RW-1:0] def_dst_q, def_sa_q, def_sb_q;

  // Memory instruction in flight
  vis_pkg::vis_mem_e m_st_q, m_st_d;
  logic [2:0] m_op_q;
  logic m_masked_q;
  logic [RW-1:0] m_vreg_q, m_off_q;
  logic [vis_pkg::ADDR_W-1:0] m_base_q;
  logic [vis_pkg::VL_W-1:0] m_vl_q;
  logic hold_q;

  // Registered outputs
  logic ai_v_q, ai_def_q, ai_div_q;
  logic [RW-1:0] ai_dst_q, ai_sa_q, ai_sb_q;
  logic mask_req_q;
  logic [vis_pkg::MASK_W-1:0] lsu_mask_q;
  logic lc_v_q;
  logic [2:0] lc_kind_q;
  logic [NR-1:0] sbw_q, sbr_q;

  logic [NR-1:0] cur_dst_m, cur_sa_m, cur_sb_m, def_dst_m, def_sa_m, def_sb_m;
  logic [NR-1:0] m_vreg_m, m_off_m, in_dst_m, in_sa_m, in_sb_m;

  wire m_idle = m_st_q == vis_pkg::M_IDLE;
  wire m_gs = (m_op_q == vis_pkg::OP_GATHER) || (m_op_q == vis_pkg::OP_SCATTER);
  wire m_st_kind = (m_op_q == vis_pkg::OP_STORE) || (m_op_q == vis_pkg::OP_SCATTER);

  vis_reg_mask u_cur_dst (.en(cur_v_q), .reg_num(cur_dst_q), .hot(cur_dst_m));
  vis_reg_mask u_cur_sa (.en(cur_v_q), .reg_num(cur_sa_q), .hot(cur_sa_m));
  vis_reg_mask u_cur_sb (.en(cur_v_q), .reg_num(cur_sb_q), .hot(cur_sb_m));
  vis_reg_mask u_def_dst (.en(def_v_q), .reg_num(def_dst_q), .hot(def_dst_m));
  vis_reg_mask u_def_sa (.en(def_v_q), .reg_num(def_sa_q), .hot(def_sa_m));
  vis_reg_mask u_def_sb (.en(def_v_q), .reg_num(def_sb_q), .hot(def_sb_m));
  vis_reg_mask u_m_vreg (.en(!m_idle), .reg_num(m_vreg_q), .hot(m_vreg_m));
  vis_reg_mask u_m_off (.en(!m_idle && m_gs), .reg_num(m_off_q), .hot(m_off_m));
  vis_reg_mask u_in_dst (.en(1'b1), .reg_num(instr_dst), .hot(in_dst_m));
  vis_reg_mask u_in_sa (.en(1'b1), .reg_num(instr_src_a), .hot(in_sa_m));
  vis_reg_mask u_in_sb (.en(1'b1), .reg_num(instr_src_b), .hot(in_sb_m));

  // Scoreboard views built from the live slots
  wire [NR-1:0] arith_w = cur_dst_m | def_dst_m;
  wire [NR-1:0] arith_r = cur_sa_m | cur_sb_m | def_sa_m | def_sb_m;
  wire [NR-1:0] def_all = def_dst_m | def_sa_m | def_sb_m;
  wire m_writes = (m_op_q == vis_pkg::OP_LOAD) || (m_op_q == vis_pkg::OP_GATHER);
  wire [NR-1:0] mem_w = m_writes ? m_vreg_m : {NR{1'b0}};
  wire [NR-1:0] mem_r = (m_writes ? {NR{1'b0}} : m_vreg_m) | m_off_m;
  wire [NR-1:0] mem_all = m_vreg_m | m_off_m;

  // Instruction decode
  wire in_div = instr_op == vis_pkg::OP_DIV;
  wire in_arith = (instr_op == vis_pkg::OP_ARITH) || in_div;
  wire in_mem = (instr_op == vis_pkg::OP_LOAD) || (instr_op == vis_pkg::OP_STORE) ||
                (instr_op == vis_pkg::OP_GATHER) || (instr_op == vis_pkg::OP_SCATTER);
  wire in_arith_conf = |((in_dst_m | in_sa_m | in_sb_m) & mem_all);
  wire arith_room = !def_v_q;
  wire arith_ok = in_arith && arith_room && !in_arith_conf && !hold_q;
  wire mem_ok = in_mem && m_idle && !hold_q;
  wire acc_arith = instr_valid && arith_ok;
  wire acc_mem = instr_valid && mem_ok;

  // Memory hazard checks against both arithmetic slots
  wire mask_writer = (cur_v_q && cur_wm_q) || (def_v_q && def_wm_q);
  wire ld_conf = |(m_vreg_m & (cur_dst_m | def_all));
  wire st_conf = |(m_vreg_m & arith_w);
  wire off_conf = |(m_off_m & arith_w);
  wire def_st_conf = |(m_vreg_m & def_dst_m);
  wire chain = m_st_kind && (m_op_q == vis_pkg::OP_STORE) && cur_v_q &&
               (m_vreg_q == cur_dst_q) && !cur_div_q && !def_st_conf;
  wire mem_block = (m_writes ? ld_conf : st_conf) || off_conf;
  wire in_check = m_st_q == vis_pkg::M_CHECK;
  wire go_chain = in_check && chain;
  wire go_off = in_check && !mem_block && !chain && m_gs;
  wire go_main_chk = in_check && !mem_block && !chain && !m_gs;
  wire go_main_chain = (m_st_q == vis_pkg::M_CHAIN) && (arith_chain_ok || arith_done);
  wire go_main_pass2 = (m_st_q == vis_pkg::M_OFFS) && lsu_offsets_done;
  wire go_main = go_main_chk || go_main_chain || go_main_pass2;
  wire in_run = m_st_q == vis_pkg::M_RUN;

  // Command kind: offset fetch, else the main pass
  wire [2:0] main_kind = (m_op_q == vis_pkg::OP_LOAD) ? vis_pkg::LK_LOAD :
                         (m_op_q == vis_pkg::OP_STORE) ? vis_pkg::LK_STORE :
                         (m_op_q == vis_pkg::OP_GATHER) ? vis_pkg::LK_GATHER :
                         vis_pkg::LK_SCATTER;
  wire [2:0] kind_d = go_off ? vis_pkg::LK_OFFSET : main_kind;
  wire safe_now = in_run && (translation_safe_signal || lsu_done);

  always_comb begin
    m_st_d = m_st_q;
    unique case (m_st_q)
      vis_pkg::M_IDLE: begin
        if (acc_mem) begin
          m_st_d = instr_masked ? vis_pkg::M_MASKW : vis_pkg::M_CHECK;
        end
      end
      vis_pkg::M_MASKW: begin
        if (!mask_writer) begin
          m_st_d = vis_pkg::M_MASKF;
        end
      end
      vis_pkg::M_MASKF: begin
        if (mask_valid) begin
          m_st_d = vis_pkg::M_CHECK;
        end
      end
      vis_pkg::M_CHECK: begin
        if (go_chain) begin
          m_st_d = vis_pkg::M_CHAIN;
        end else if (go_off) begin
          m_st_d = vis_pkg::M_OFFS;
        end else if (go_main_chk) begin
          m_st_d = vis_pkg::M_RUN;
        end
      end
      vis_pkg::M_CHAIN: begin
        if (go_main_chain) begin
          m_st_d = vis_pkg::M_RUN;
        end
      end
      vis_pkg::M_OFFS: begin
        if (go_main_pass2) begin
          m_st_d = vis_pkg::M_RUN;
        end
      end
      vis_pkg::M_RUN: begin
        if (lsu_done) begin
          m_st_d = vis_pkg::M_IDLE;
        end
      end
      default: m_st_d = vis_pkg::M_IDLE;
    endcase
  end

  // Arithmetic slots: deferred moves up when the executing one retires
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cur_v_q <= 1'b0;
      cur_div_q <= 1'b0;
      cur_wm_q <= 1'b0;
      cur_dst_q <= '0;
      cur_sa_q <= '0;
      cur_sb_q <= '0;
    end else if (arith_done && def_v_q) begin
      cur_v_q <= 1'b1;
      cur_div_q <= def_div_q;
      cur_wm_q <= def_wm_q;
      cur_dst_q <= def_dst_q;
      cur_sa_q <= def_sa_q;
      cur_sb_q <= def_sb_q;
    end else if (acc_arith && (!cur_v_q || arith_done)) begin
      cur_v_q <= 1'b1;
      cur_div_q <= in_div;
      cur_wm_q <= instr_wr_mask;
      cur_dst_q <= instr_dst;
      cur_sa_q <= instr_src_a;
      cur_sb_q <= instr_src_b;
    end else if (arith_done) begin
      cur_v_q <= 1'b0;
    end
  end

  wire to_def = acc_arith && cur_v_q && !arith_done;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      def_v_q <= 1'b0;
      def_div_q <= 1'b0;
      def_wm_q <= 1'b0;
      def_dst_q <= '0;
      def_sa_q <= '0;
      def_sb_q <= '0;
    end else if (to_def) begin
      def_v_q <= 1'b1;
      def_div_q <= in_div;
      def_wm_q <= instr_wr_mask;
      def_dst_q <= instr_dst;
      def_sa_q <= instr_src_a;
      def_sb_q <= instr_src_b;
    end else if (arith_done) begin
      def_v_q <= 1'b0;
    end
  end

  // Memory instruction latch and sequencing
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      m_st_q <= vis_pkg::M_IDLE;
      m_op_q <= vis_pkg::OP_LOAD;
      m_masked_q <= 1'b0;
      m_vreg_q <= '0;
      m_off_q <= '0;
      m_base_q <= '0;
      m_vl_q <= '0;
    end else begin
      m_st_q <= m_st_d;
      if (acc_mem) begin
        m_op_q <= instr_op;
        m_masked_q <= instr_masked;
        m_vreg_q <= instr_dst;
        m_off_q <= instr_src_a;
        m_base_q <= instr_base;
        m_vl_q <= vector_length_value;
      end
    end
  end

  // Issue stays closed from memory acceptance until translations are safe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hold_q <= 1'b0;
    end else if (acc_mem) begin
      hold_q <= 1'b1;
    end else if (safe_now) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mask_req_q <= 1'b0;
      lsu_mask_q <= vis_pkg::MASK_ALL;
    end else begin
      mask_req_q <= (m_st_q == vis_pkg::M_MASKW) && !mask_writer;
      if (acc_mem) begin
        lsu_mask_q <= vis_pkg::MASK_ALL;
      end else if ((m_st_q == vis_pkg::M_MASKF) && mask_valid) begin
        lsu_mask_q <= mask_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lc_v_q <= 1'b0;
      lc_kind_q <= vis_pkg::LK_LOAD;
    end else begin
      lc_v_q <= go_off || go_main;
      if (go_off || go_main) begin
        lc_kind_q <= kind_d;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ai_v_q <= 1'b0;
      ai_def_q <= 1'b0;
      ai_div_q <= 1'b0;
      ai_dst_q <= '0;
      ai_sa_q <= '0;
      ai_sb_q <= '0;
    end else begin
      ai_v_q <= acc_arith;
      if (acc_arith) begin
        ai_def_q <= to_def;
        ai_div_q <= in_div;
        ai_dst_q <= instr_dst;
        ai_sa_q <= instr_src_a;
        ai_sb_q <= instr_src_b;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sbw_q <= '0;
      sbr_q <= '0;
    end else begin
      sbw_q <= arith_w | mem_w;
      sbr_q <= arith_r | mem_r;
    end
  end

  vis_offset_store u_offs (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wr_en(off_wr_valid && (m_st_q == vis_pkg::M_OFFS)),
    .wr_idx(off_wr_idx),
    .wr_data(off_wr_data),
    .rd_en(elem_req && in_run && m_gs),
    .rd_idx(elem_idx),
    .vlen(m_vl_q),
    .base(m_base_q),
    .out_valid(elem_valid),
    .out_addr(elem_addr),
    .out_idx(elem_dst_idx)
  );

  assign instr_ready = arith_ok || mem_ok;
  assign arith_issue_valid = ai_v_q;
  assign arith_issue_deferred = ai_def_q;
  assign arith_issue_div = ai_div_q;
  assign arith_issue_dst = ai_dst_q;
  assign arith_issue_src_a = ai_sa_q;
  assign arith_issue_src_b = ai_sb_q;
  assign mask_req = mask_req_q;
  assign lsu_cmd_valid = lc_v_q;
  assign lsu_cmd_kind = lc_kind_q;
  assign lsu_cmd_vreg = m_vreg_q;
  assign lsu_cmd_offreg = m_off_q;
  assign lsu_cmd_base = m_base_q;
  assign lsu_mask = lsu_mask_q;
  assign scalar_resume = !hold_q;
  assign sb_write_busy = sbw_q;
  assign sb_read_busy = sbr_q;
endmodule

//--- test/vis_top_asserts.sv
// Checker for vis_top: issue handshake, memory sequencing, mask and element addresses.
// Bound to vis_top; sees only its ports.
`timescale 1ns/1ps
module vis_top_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [2:0] instr_op,
  input wire logic instr_masked,
  input wire logic arith_issue_valid,
  input wire logic arith_issue_deferred,
  input wire logic arith_done,
  input wire logic mask_valid,
  input wire logic [vis_pkg::MASK_W-1:0] mask_data,
  input wire logic lsu_cmd_valid,
  input wire logic [2:0] lsu_cmd_kind,
  input wire logic [vis_pkg::ADDR_W-1:0] lsu_cmd_base,
  input wire logic [vis_pkg::MASK_W-1:0] lsu_mask,
  input wire logic lsu_offsets_done,
  input wire logic translation_safe_signal,
  input wire logic scalar_resume,
  input wire logic off_wr_valid,
  input wire logic [vis_pkg::IDX_W-1:0] off_wr_idx,
  input wire logic [vis_pkg::ADDR_W-1:0] off_wr_data,
  input wire logic elem_req,
  input wire logic [vis_pkg::IDX_W-1:0] elem_idx,
  input wire logic elem_valid,
  input wire logic [vis_pkg::ADDR_W-1:0] elem_addr,
  input wire logic [vis_pkg::IDX_W-1:0] elem_dst_idx,
  input wire logic [vis_pkg::NREG-1:0] sb_write_busy,
  input wire logic [vis_pkg::NREG-1:0] sb_read_busy
);
  logic [vis_pkg::ADDR_W-1:0] off_q [vis_pkg::VL_MAX];
  logic [vis_pkg::MASK_W-1:0] mask_q;
  logic masked_q;
  wire acc = instr_valid && instr_ready;
  wire clean = !arith_issue_valid && sb_write_busy == '0;

  // Shadow copies of the offsets and the last fetched mask
  always_ff @(posedge clk_sys) begin
    if (off_wr_valid) off_q[off_wr_idx] <= off_wr_data;
    if (!nrst) mask_q <= vis_pkg::MASK_ALL;
    else if (mask_valid) mask_q <= mask_data;
    if (!nrst) masked_q <= 1'b0;
    else if (acc && instr_op inside {[3'h2:3'h5]}) masked_q <= instr_masked;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_arith_pulse;
    acc && instr_op <= 3'h1 |=> arith_issue_valid;
  endproperty
  a_arith_pulse: assert property (p_arith_pulse)
    else $error("arith issue pulse missing");
  property p_def_full;
    arith_issue_valid && arith_issue_deferred && !arith_done |-> !(acc && instr_op <= 3'h1);
  endproperty
  a_def_full: assert property (p_def_full)
    else $error("arith taken with deferred slot full");
  property p_hold_path;
    !scalar_resume |-> !instr_ready;
  endproperty
  a_hold_path: assert property (p_hold_path)
    else $error("issue while path held");
  property p_mem_gap;
    acc && instr_op inside {[3'h2:3'h5]} |=> !instr_ready [*2];
  endproperty
  a_mem_gap: assert property (p_mem_gap)
    else $error("issue right after memory op");
  property p_resume;
    !scalar_resume && translation_safe_signal |=> scalar_resume;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume late after translation safe");
  property p_second_pass;
    lsu_offsets_done |=> lsu_cmd_valid && lsu_cmd_kind inside {3'h3, 3'h4};
  endproperty
  a_second_pass: assert property (p_second_pass)
    else $error("main pass not reissued");
  property p_offset_cmd;
    acc && instr_op inside {3'h4, 3'h5} && !instr_masked && clean |-> ##2 lsu_cmd_valid && lsu_cmd_kind == 3'h2;
  endproperty
  a_offset_cmd: assert property (p_offset_cmd)
    else $error("offset fetch not dispatched");
  property p_load_lat;
    acc && instr_op == 3'h2 && !instr_masked && clean |-> ##2 lsu_cmd_valid && lsu_cmd_kind == 3'h0;
  endproperty
  a_load_lat: assert property (p_load_lat)
    else $error("free load not dispatched");
  property p_elem_idx;
    elem_valid |-> $past(elem_req) && elem_dst_idx == $past(elem_idx);
  endproperty
  a_elem_idx: assert property (p_elem_idx)
    else $error("element index wrong");
  property p_elem_addr;
    elem_valid |-> elem_addr == lsu_cmd_base + off_q[elem_dst_idx];
  endproperty
  a_elem_addr: assert property (p_elem_addr)
    else $error("element address wrong");
  property p_mask_fwd;
    lsu_cmd_valid |-> lsu_mask == (masked_q ? mask_q : vis_pkg::MASK_ALL);
  endproperty
  a_mask_fwd: assert property (p_mask_fwd)
    else $error("mask not forwarded");

  c_gather: cover property (acc && instr_op == 3'h4);
  c_offsets: cover property (lsu_offsets_done);
  c_mask: cover property (mask_valid);
  c_deferred: cover property (arith_issue_valid && arith_issue_deferred);
endmodule

bind vis_top vis_top_checker u_chk (.*);

//--- test/vis_lsu_model.sv
// Load/store unit stand-in: answers commands, writes offsets, requests element addresses.
// Drives off the falling edge; lsu_slow sets the delay before each command starts.
`timescale 1ns/1ps
module vis_lsu_model (
  input wire logic clk_sys,
  input wire logic lsu_cmd_valid,
  input wire logic [2:0] lsu_cmd_kind,
  input wire logic [vis_pkg::VL_W-1:0] vector_length_value,
  input wire logic [3:0] lsu_slow,
  output logic translation_safe_signal,
  output logic lsu_offsets_done,
  output logic lsu_done,
  output logic off_wr_valid,
  output logic [vis_pkg::IDX_W-1:0] off_wr_idx,
  output logic [vis_pkg::ADDR_W-1:0] off_wr_data,
  output logic elem_req,
  output logic [vis_pkg::IDX_W-1:0] elem_idx
);
  task automatic serve();
    int i;
    repeat (lsu_slow) @(negedge clk_sys);
    if (lsu_cmd_kind == 3'h2) begin
      for (i = 0; i < vector_length_value; i++) begin
        off_wr_valid = 1'b1;
        off_wr_idx = i[5:0];
        off_wr_data = 32'(i * 16 + 8);
        @(negedge clk_sys);
      end
      off_wr_valid = 1'b0;
      off_wr_data = ~off_wr_data;
      lsu_offsets_done = 1'b1;
    end else begin
      for (i = 0; lsu_cmd_kind > 3'h2 && i < vector_length_value; i++) begin
        elem_req = 1'b1;
        elem_idx = i[5:0];
        @(negedge clk_sys);
      end
      elem_req = 1'b0;
      elem_idx = ~elem_idx;
      translation_safe_signal = 1'b1;
      @(negedge clk_sys);
      translation_safe_signal = 1'b0;
      repeat (lsu_slow) @(negedge clk_sys);
      lsu_done = 1'b1;
    end
    @(negedge clk_sys);
    lsu_offsets_done = 1'b0;
    lsu_done = 1'b0;
  endtask

  initial begin
    translation_safe_signal = 1'b0;
    lsu_offsets_done = 1'b0;
    lsu_done = 1'b0;
    off_wr_valid = 1'b0;
    off_wr_idx = '0;
    off_wr_data = '0;
    elem_req = 1'b0;
    elem_idx = '0;
    forever begin
      @(negedge clk_sys);
      while (lsu_cmd_valid === 1'b1) serve();
    end
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for vis_top with a load/store unit stand-in.
// The bench plays the scalar issue unit and the arithmetic unit.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t %0h %0h", $time, a, b); end end
module testbench;
  logic clk_sys, nrst, instr_valid, instr_ready, instr_masked, instr_wr_mask, arith_issue_valid;
  logic arith_issue_deferred, arith_issue_div, arith_done, arith_chain_ok, mask_req, mask_valid;
  logic lsu_cmd_valid, lsu_offsets_done, lsu_done, translation_safe_signal, scalar_resume;
  logic off_wr_valid, elem_req, elem_valid;
  logic [2:0] instr_op, lsu_cmd_kind;
  logic [vis_pkg::REG_W-1:0] instr_dst, instr_src_a, instr_src_b, arith_issue_dst, arith_issue_src_a;
  logic [vis_pkg::REG_W-1:0] arith_issue_src_b, lsu_cmd_vreg, lsu_cmd_offreg;
  logic [vis_pkg::ADDR_W-1:0] instr_base, lsu_cmd_base, off_wr_data, elem_addr;
  logic [vis_pkg::VL_W-1:0] vector_length_value;
  logic [vis_pkg::MASK_W-1:0] mask_data, lsu_mask;
  logic [vis_pkg::IDX_W-1:0] off_wr_idx, elem_idx, elem_dst_idx;
  logic [vis_pkg::NREG-1:0] sb_write_busy, sb_read_busy;
  logic [3:0] lsu_slow;
  int num_errors, checks, elem_cnt;
  wire [3:0] ev = {mask_req, lsu_done, lsu_cmd_valid, arith_issue_valid};

  vis_top dut (.*);
  vis_lsu_model u_lsu (.*);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n > 300) begin
      num_errors++;
      complete_run();
    end
  endtask

  // Looks 1 ns after the call and 1 ns past each rising edge, where stand-in and design outputs have settled
  task automatic wait_ev(input int b);
    int n;
    n = 0;
    #1;
    while (ev[b] !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      guard(n);
    end
    @(negedge clk_sys);
  endtask

  task automatic send(input logic [2:0] op, input logic [3:0] d, a, b, input logic m, w);
    int n;
    n = 0;
    // An edge passes so valid is never lowered and raised in one step
    @(negedge clk_sys);
    instr_op = op;
    instr_dst = d;
    instr_src_a = a;
    instr_src_b = b;
    instr_masked = m;
    instr_wr_mask = w;
    instr_valid = 1'b1;
    #1;
    while (instr_ready !== 1'b1) begin
      @(negedge clk_sys);
      #1;
      n++;
      guard(n);
    end
    @(negedge clk_sys);
    instr_valid = 1'b0;
  endtask

  task automatic pdone();
    arith_done = 1'b1;
    @(negedge clk_sys);
    arith_done = 1'b0;
  endtask

  // Element addresses follow the stand-in's offsets: index * 16 + 8
  always @(negedge clk_sys) begin
    if (elem_valid === 1'b1) begin
      elem_cnt++;
      `CHK(elem_addr, instr_base + {elem_dst_idx, 4'h8})
    end
  end

  task automatic s_arith();
    send(3'h0, 4'h3, 4'h1, 4'h2, 1'b0, 1'b0);
    `CHK(arith_issue_valid, 1'b1)
    `CHK(arith_issue_deferred, 1'b0)
    send(3'h0, 4'h4, 4'h3, 4'h1, 1'b0, 1'b0);
    `CHK(arith_issue_deferred, 1'b1)
    fork
      send(3'h0, 4'h5, 4'h6, 4'h7, 1'b0, 1'b0);
      begin
        repeat (3) @(negedge clk_sys);
        `CHK(instr_ready, 1'b0)
        pdone();
      end
    join
    `CHK(arith_issue_dst, 4'h5)
    `CHK(arith_issue_deferred, 1'b1)
  endtask

  // Load overwrites a source of the deferred add: held until it starts
  task automatic s_load();
    send(3'h2, 4'h6, 4'h0, 4'h0, 1'b0, 1'b0);
    repeat (5) begin
      `CHK(lsu_cmd_valid, 1'b0)
      `CHK(instr_ready, 1'b0)
      @(negedge clk_sys);
    end
    pdone();
    wait_ev(1);
    `CHK(lsu_cmd_vreg, 4'h6)
    wait_ev(2);
    pdone();
    repeat (2) @(negedge clk_sys);
    `CHK(sb_write_busy, 16'h0000)
  endtask

  task automatic s_gather();
    logic [2:0] op;
    for (op = 3'h4; op <= 3'h5; op++) begin
      elem_cnt = 0;
      send(op, 4'h7, 4'h8, 4'h0, 1'b0, 1'b0);
      wait_ev(2);
      `CHK(elem_cnt, 5)
      `CHK(lsu_cmd_kind, op - 3'h1)
    end
  endtask

  task automatic s_mask();
    send(3'h0, 4'h0, 4'h1, 4'h2, 1'b0, 1'b1);
    send(3'h2, 4'hD, 4'h0, 4'h0, 1'b1, 1'b0);
    repeat (4) begin
      `CHK(mask_req, 1'b0)
      @(negedge clk_sys);
    end
    pdone();
    wait_ev(3);
    mask_valid = 1'b1;
    mask_data = 64'h0123_4567_89AB_CDEF;
    @(negedge clk_sys);
    mask_valid = 1'b0;
    mask_data = ~mask_data;
    wait_ev(1);
    `CHK(lsu_mask, 64'h0123_4567_89AB_CDEF)
    wait_ev(2);
  endtask

  // Store of the running add's result waits for the arithmetic start signal
  task automatic s_chain();
    send(3'h0, 4'h3, 4'h1, 4'h2, 1'b0, 1'b0);
    send(3'h3, 4'h3, 4'h0, 4'h0, 1'b0, 1'b0);
    repeat (3) begin
      `CHK(lsu_cmd_valid, 1'b0)
      @(negedge clk_sys);
    end
    arith_chain_ok = 1'b1;
    @(negedge clk_sys);
    arith_chain_ok = 1'b0;
    wait_ev(1);
    `CHK(lsu_cmd_kind, 3'h1)
    wait_ev(2);
    pdone();
  endtask

  // Prompt stand-in; a load and a store overlap one divide and finish first
  task automatic s_div();
    int i;
    lsu_slow = 4'h0;
    send(3'h2, 4'h9, 4'h0, 4'h0, 1'b0, 1'b0);
    wait_ev(2);
    send(3'h1, 4'hA, 4'h1, 4'h2, 1'b0, 1'b0);
    `CHK(arith_issue_div, 1'b1)
    send(3'h0, 4'hB, 4'h3, 4'h4, 1'b0, 1'b0);
    for (i = 0; i < 2; i++) begin
      send(3'h2 + i[2:0], 4'hC, 4'h0, 4'h0, 1'b0, 1'b0);
      @(negedge clk_sys);
      `CHK(lsu_cmd_valid, 1'b1)
      `CHK(lsu_cmd_kind, i[2:0])
      wait_ev(2);
    end
    `CHK(sb_write_busy[10], 1'b1)
    pdone();
    pdone();
  endtask

  initial begin
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr_op = 3'h0;
    instr_dst = 4'h0;
    instr_src_a = 4'h0;
    instr_src_b = 4'h0;
    instr_masked = 1'b0;
    instr_wr_mask = 1'b0;
    instr_base = 32'h0000_1000;
    vector_length_value = 7'h05;
    arith_done = 1'b0;
    arith_chain_ok = 1'b0;
    mask_valid = 1'b0;
    mask_data = '0;
    lsu_slow = 4'h6;
    num_errors = 0;
    checks = 0;
    elem_cnt = 0;
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    s_arith();
    s_load();
    s_gather();
    s_mask();
    s_chain();
    s_div();
    complete_run();
  end
endmodule
